// ==== inc/plh_pkg.sv ====
// Shared constants and types for the port-level handshake block.
// Assumes a single synchronous clock domain.
package plh_pkg;
	localparam int DATA_W = 32;
	localparam int FIFO_DEPTH = 4;
	localparam int FIFO_AW = 2;
	localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
	localparam logic [DATA_W-1:0] RESULT_INC = 32'h0000_0001;

	// Transaction sequencer states
	typedef enum logic [2:0] {
		PLH_IDLE = 3'b000,
		PLH_READ = 3'b001,
		PLH_SUM = 3'b010,
		PLH_ACKWAIT = 3'b011,
		PLH_ACKONLY = 3'b100,
		PLH_DONE = 3'b101
	} plh_state_e;
endpackage

// ==== hw/plh_fifo.sv ====
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module plh_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4,
	parameter int AW = 2
) (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic [WIDTH-1:0] wr_data_i,
	input wire logic wr_valid_i,
	output logic wr_ready_o,
	output logic [WIDTH-1:0] rd_data_o,
	output logic rd_valid_o,
	input wire logic rd_ready_i
);
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} plh_fifo_s;

	plh_fifo_s st_r;
	plh_fifo_s st_nxt;
	logic [WIDTH-1:0] mem [DEPTH];
	logic do_wr;
	logic do_rd;

	// Flags and transfer strobes
	assign wr_ready_o = (st_r.cnt != DEPTH[AW:0]);
	assign rd_valid_o = (st_r.cnt != '0);
	assign rd_data_o = mem[st_r.rp];
	assign do_wr = wr_valid_i && wr_ready_o;
	assign do_rd = rd_valid_o && rd_ready_i;

	// Pointer and count update
	always_comb begin
		st_nxt = st_r;
		if (do_wr) begin
			st_nxt.wp = st_r.wp + 1'b1;
		end
		if (do_rd) begin
			st_nxt.rp = st_r.rp + 1'b1;
		end
		if (do_wr && !do_rd) begin
			st_nxt.cnt = st_r.cnt + 1'b1;
		end else if (do_rd && !do_wr) begin
			st_nxt.cnt = st_r.cnt - 1'b1;
		end
	end

	// State register
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Storage array, no reset needed
	always_ff @(posedge core_clk_i) begin
		if (do_wr) begin
			mem[st_r.wp] <= wr_data_i;
		end
	end
endmodule
`default_nettype wire

// ==== hw/plh_core.sv ====
// Function block with port-level protocols: plain wire inputs, a
// handshaked input and output, acknowledge-only ports, a valid-only
// input, a split in-out argument and start/idle/ready/done control.
// Assumes producers and consumers are logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// [RQ1] Producer holds plain-wire inputs stable until read or transaction ends.
// [RQ2] Each output pointer port has a valid asserted when data may be read.
// [RQ3] A read-written argument becomes separate input and output ports.
// [RQ4] Finish pulse also marks the result value port as valid.
// [RQ5] A High go request starts a transaction.
// [RQ6] Quiescent flag Low while busy, High when waiting for go.
// [RQ7] Inputs-taken flag goes High once every input has been read.
// [RQ8] Inputs are read after the first transaction cycle, per schedule.
// [RQ9] No-protocol ports carry data only, no valid or acknowledge.
// [RQ10] No-protocol mode is never used for array arguments.
// [RQ11] Handshake input: stall while input valid is Low.
// [RQ12] Handshake input: acknowledge High in the cycle the data is taken.
// [RQ13] Handshake output: valid rises with the new data.
// [RQ14] Handshake output: stall until the consumer acknowledges.
// [RQ15] Output valid drops on the edge after the acknowledge.
// [RQ16] Acknowledge-only input: acknowledge High in the read cycle.
// [RQ17] Acknowledge-only output: no valid; stall until acknowledge High.
// [RQ18] Valid-only input is captured whenever valid, held until needed.
// [RQ19] Split in-out: input half plain wire, output half valid-only.
// [RQ20] All control is synchronous to the rising clock edge; the active-low reset rst_b_i acts asynchronously.
module plh_core
	import plh_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic go_request_i,
	output logic quiescent_flag_o,
	output logic inputs_taken_flag_o,
	output logic finish_pulse_o,
	output logic [DATA_W-1:0] result_value_port_o,
	input wire logic [DATA_W-1:0] a_i,
	input wire logic [DATA_W-1:0] b_i,
	input wire logic [DATA_W-1:0] hs_in_i,
	input wire logic hs_in_vld_i,
	output logic hs_in_ack_o,
	output logic [DATA_W-1:0] hs_out_o,
	output logic hs_out_vld_o,
	input wire logic hs_out_ack_i,
	input wire logic [DATA_W-1:0] ack_in_i,
	output logic ack_in_ack_o,
	output logic [DATA_W-1:0] ack_out_o,
	input wire logic ack_out_ack_i,
	input wire logic [DATA_W-1:0] vld_in_i,
	input wire logic vld_in_vld_i,
	input wire logic [DATA_W-1:0] result_i,
	output logic [DATA_W-1:0] result_o,
	output logic result_out_valid_o,
	output logic [DATA_W-1:0] sum_o,
	output logic sum_out_valid_o
);
	typedef struct packed {
		plh_state_e st;
		logic idle;
		logic rdy;
		logic done;
		logic [DATA_W-1:0] ret;
		logic hs_ack;
		logic [DATA_W-1:0] hs_dat;
		logic hs_vld;
		logic ak_ack;
		logic [DATA_W-1:0] ak_out;
		logic [DATA_W-1:0] vld_hold;
		logic vld_full;
		logic [DATA_W-1:0] res;
		logic res_vld;
		logic [DATA_W-1:0] sum;
		logic sum_vld;
		logic [DATA_W-1:0] hs_word;
	} plh_core_s;

	plh_core_s s_r;
	plh_core_s s_nxt;

	// Handshake input passes through the FIFO; stalls propagate back
	logic [DATA_W-1:0] fifo_data;
	logic fifo_valid;
	logic fifo_ready;
	logic fifo_take;
	logic fifo_push;

	// Add two words, used for sum and in-out update
	function automatic logic [DATA_W-1:0] add_w(
		input logic [DATA_W-1:0] x,
		input logic [DATA_W-1:0] y
	);
		add_w = x + y;
	endfunction

	// The FIFO's fill-side ready is the input acknowledge source
	plh_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.core_clk_i(core_clk_i),
		.rst_b_i(rst_b_i),
		.wr_data_i(hs_in_i),
		.wr_valid_i(fifo_push),
		.wr_ready_o(fifo_ready),
		.rd_data_o(fifo_data),
		.rd_valid_o(fifo_valid),
		.rd_ready_i(fifo_take)
	);

	// One word per acknowledge: a held valid must not be written twice
	assign fifo_push = hs_in_vld_i && !s_r.hs_ack; // RQ12

	// Drain one word only when the read state really advances
	assign fifo_take = (s_r.st == PLH_READ) && fifo_valid && s_r.vld_full; // RQ11

	// Sequencer and port logic
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		s_nxt.rdy = 1'b0;
		s_nxt.ak_ack = 1'b0;
		// Acknowledge exactly when the FIFO accepts the word
		s_nxt.hs_ack = hs_in_vld_i && fifo_ready && !s_r.hs_ack; // RQ12
		// Valid-only input is captured whenever presented
		if (vld_in_vld_i) begin
			s_nxt.vld_hold = vld_in_i; // RQ18
			s_nxt.vld_full = 1'b1;
		end
		// Output valid drops the edge after acknowledge
		if (s_r.hs_vld && hs_out_ack_i) begin
			s_nxt.hs_vld = 1'b0; // RQ15
		end
		case (s_r.st)
			PLH_IDLE: begin
				s_nxt.idle = 1'b1;
				if (go_request_i) begin
					s_nxt.idle = 1'b0; // RQ5 RQ6 RQ20
					s_nxt.res_vld = 1'b0;
					s_nxt.sum_vld = 1'b0;
					s_nxt.st = PLH_READ;
				end
			end
			PLH_READ: begin
				// Reads only after the first cycle; wait for valid
				if (fifo_valid && s_r.vld_full) begin // RQ8 RQ11
					s_nxt.hs_word = fifo_data;
					s_nxt.vld_full = vld_in_vld_i;
					s_nxt.st = PLH_SUM;
				end
			end
			PLH_SUM: begin
				// Plain wires a_i, b_i, result_i sampled here, held by producer
				s_nxt.sum = add_w(a_i, b_i); // RQ1 RQ9
				s_nxt.sum_vld = 1'b1; // RQ2
				s_nxt.res = add_w(result_i, RESULT_INC); // RQ3 RQ19
				s_nxt.res_vld = 1'b1; // RQ19
				s_nxt.hs_dat = add_w(s_r.hs_word, s_r.vld_hold);
				s_nxt.hs_vld = 1'b1; // RQ13
				// Acknowledge-only input read here; all inputs now taken
				s_nxt.ak_out = add_w(s_r.hs_word, ack_in_i);
				s_nxt.ak_ack = 1'b1; // RQ16
				s_nxt.rdy = 1'b1; // RQ7
				s_nxt.st = PLH_ACKWAIT;
			end
			PLH_ACKWAIT: begin
				// Stall until consumer acknowledges the output
				if (s_r.hs_vld && hs_out_ack_i) begin // RQ14
					s_nxt.st = PLH_ACKONLY;
				end
			end
			PLH_ACKONLY: begin
				// No valid line; wait for consumer acknowledge
				if (ack_out_ack_i) begin // RQ17
					s_nxt.ret = add_w(s_r.sum, s_r.res);
					s_nxt.done = 1'b1; // RQ4
					s_nxt.st = PLH_DONE;
				end
			end
			PLH_DONE: begin
				s_nxt.idle = 1'b1; // RQ6
				s_nxt.st = PLH_IDLE;
			end
			default: begin
				s_nxt.st = PLH_IDLE;
			end
		endcase
	end

	// Register all state; no array arguments use plain wires RQ10
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_r <= '0;
			s_r.st <= PLH_IDLE;
			s_r.idle <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from flip-flops
	assign quiescent_flag_o = s_r.idle;
	assign inputs_taken_flag_o = s_r.rdy;
	assign finish_pulse_o = s_r.done;
	assign result_value_port_o = s_r.ret;
	assign hs_in_ack_o = s_r.hs_ack;
	assign hs_out_o = s_r.hs_dat;
	assign hs_out_vld_o = s_r.hs_vld;
	assign ack_in_ack_o = s_r.ak_ack;
	assign ack_out_o = s_r.ak_out;
	assign result_o = s_r.res;
	assign result_out_valid_o = s_r.res_vld;
	assign sum_o = s_r.sum;
	assign sum_out_valid_o = s_r.sum_vld;
endmodule
`default_nettype wire

// ==== bench/plh_core_sva.sv ====
// Timing checker for the control and handshake ports of plh_core.
// Bound to every plh_core; one clock, asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module plh_core_sva (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic go_request_i,
	input wire logic quiescent_flag_o,
	input wire logic inputs_taken_flag_o,
	input wire logic finish_pulse_o,
	input wire logic hs_in_vld_i,
	input wire logic hs_in_ack_o,
	input wire logic hs_out_vld_o,
	input wire logic hs_out_ack_i,
	input wire logic ack_in_ack_o,
	input wire logic ack_out_ack_i,
	input wire logic sum_out_valid_o,
	input wire logic result_out_valid_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	a_go_busy: assert property (quiescent_flag_o && go_request_i
		|=> !quiescent_flag_o) else $error("go not taken");
	a_done_idle: assert property (finish_pulse_o
		|-> !$past(quiescent_flag_o) ##1 quiescent_flag_o) else $error("idle");
	a_in_ack: assert property (hs_in_ack_o
		|-> $past(hs_in_vld_i) && !$past(hs_in_ack_o)) else $error("in ack");
	a_out_hold: assert property (hs_out_vld_o && !hs_out_ack_i
		|=> hs_out_vld_o) else $error("valid dropped early");
	a_out_drop: assert property (hs_out_vld_o && hs_out_ack_i
		|=> !hs_out_vld_o) else $error("valid not dropped");
	a_taken_one: assert property (inputs_taken_flag_o
		|=> !inputs_taken_flag_o && sum_out_valid_o) else $error("taken");
	a_vld_with: assert property ($rose(sum_out_valid_o)
		|-> result_out_valid_o && hs_out_vld_o) else $error("valids apart");
	a_ack_one: assert property (ack_in_ack_o
		|=> !ack_in_ack_o) else $error("ack not one cycle");
	a_fin_ack: assert property (finish_pulse_o
		|-> $past(ack_out_ack_i) ) else $error("finish without ack");
endmodule
bind plh_core plh_core_sva i_sva (.*);
`default_nettype wire

// ==== bench/plh_sink.sv ====
// Consumer model for the handshaked and acknowledge-only outputs.
// Acts on the falling edge; dly_i sets the stall before each ack.
`timescale 1ns/1ps
`default_nettype none
module plh_sink (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic hs_out_vld_o,
	input wire logic [3:0] dly_i,
	output logic hs_out_ack_i,
	output logic ack_out_ack_i
);
	logic [3:0] cnt;
	logic pend;
	// Wait dly_i cycles on each output, then acknowledge for one cycle
	always @(negedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt <= 4'h0;
			pend <= 1'h0;
			hs_out_ack_i <= 1'h0;
			ack_out_ack_i <= 1'h0;
		end else begin
			hs_out_ack_i <= 1'h0;
			ack_out_ack_i <= 1'h0;
			if (hs_out_vld_o && !hs_out_ack_i || pend && !ack_out_ack_i) begin
				cnt <= cnt + 4'h1;
				if (cnt == dly_i) begin
					cnt <= 4'h0;
					hs_out_ack_i <= hs_out_vld_o;
					ack_out_ack_i <= !hs_out_vld_o;
					pend <= hs_out_vld_o;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== bench/tb_plh_core.sv ====
// Self-checking bench for plh_core with a consumer model on its outputs.
// Drives inputs on the falling edge; 50 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_plh_core
	import plh_pkg::*;
;
	logic core_clk_i = 1'h0, rst_b_i = 1'h0, go_request_i = 1'h0;
	logic hs_in_vld_i = 1'h0, vld_in_vld_i = 1'h0;
	logic [DATA_W-1:0] a_i = ZERO_WORD, b_i = ZERO_WORD, hs_in_i = ZERO_WORD;
	logic [DATA_W-1:0] ack_in_i = ZERO_WORD, vld_in_i = ZERO_WORD;
	logic [DATA_W-1:0] result_i = ZERO_WORD;
	logic [3:0] dly_i = 4'h0;
	logic quiescent_flag_o, inputs_taken_flag_o, finish_pulse_o, hs_in_ack_o;
	logic hs_out_vld_o, ack_in_ack_o, result_out_valid_o, sum_out_valid_o;
	logic hs_out_ack_i, ack_out_ack_i;
	logic [DATA_W-1:0] result_value_port_o, hs_out_o, ack_out_o, result_o, sum_o;
	int n_mismatch = 0, compares = 0, cyc = 0;
	logic [DATA_W-1:0] rows [3][6] = '{'{32'h0000_0001, 32'h0000_0002,
		32'h0000_0003, 32'h0000_0004, 32'h0000_0005, 32'h0000_0006},
		'{6{32'hFFFF_FFFF}}, '{6{32'h8000_0000}}};

	plh_core i_dut (.*);
	plh_sink i_sink (.*);

	// Clock and hang limit
	always #10 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc > 2000) begin
			n_mismatch++;
			results;
		end
	end

	task chk(input string nm, input logic [DATA_W-1:0] s, e);
		compares++;
		if (s !== e) begin
			n_mismatch++;
			$display("MISMATCH %s exp %h got %h", nm, e, s);
		end
	endtask

	task push(input logic [DATA_W-1:0] d, input logic exp);
		int n;
		@(negedge core_clk_i);
		hs_in_i = d;
		hs_in_vld_i = 1'h1;
		n = 0;
		do begin
			@(negedge core_clk_i);
			n++;
		end while (hs_in_ack_o !== 1'h1 && n < 8);
		chk("hs_in_ack_o", hs_in_ack_o, exp);
		hs_in_vld_i = 1'h0;
		hs_in_i = ~d;
	endtask

	task txn(input logic [DATA_W-1:0] h, v, x, y, z, w, input logic pu);
		int n;
		int nt;
		int na;
		@(negedge core_clk_i);
		a_i = x;
		b_i = y;
		ack_in_i = z;
		result_i = w;
		vld_in_i = v;
		vld_in_vld_i = 1'h1;
		@(negedge core_clk_i);
		vld_in_vld_i = 1'h0;
		vld_in_i = ~v;
		go_request_i = 1'h1;
		@(negedge core_clk_i);
		go_request_i = 1'h0;
		chk("quiescent_flag_o", quiescent_flag_o, 0);
		if (pu) push(h, 1'h1);
		n = 0;
		nt = 0;
		na = 0;
		while (finish_pulse_o !== 1'h1 && n < 40) begin
			@(negedge core_clk_i);
			n++;
			nt += (inputs_taken_flag_o === 1'h1);
			na += (ack_in_ack_o === 1'h1);
		end
		chk("finish_pulse_o", finish_pulse_o, 1);
		chk("inputs_taken_count", nt, 1);
		chk("ack_in_ack_count", na, 1);
		chk("hs_out_vld_o", hs_out_vld_o, 0);
		chk("result_out_valid_o", result_out_valid_o, 1);
		chk("sum_o", sum_o, x + y);
		chk("result_o", result_o, w + RESULT_INC);
		chk("result_value", result_value_port_o, x + y + w + RESULT_INC);
		chk("hs_out_o", hs_out_o, h + v);
		chk("ack_out_o", ack_out_o, h + z);
		chk("sum_out_valid_o", sum_out_valid_o, 1);
	endtask

	task results;
		if (n_mismatch == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Reset, table rows, then fill the FIFO until refused and drain it
	initial begin
		repeat (3) @(posedge core_clk_i);
		@(negedge core_clk_i);
		rst_b_i = 1'h1;
		chk("quiescent_flag_o", quiescent_flag_o, 1);
		foreach (rows[i]) begin
			dly_i = 4'(i * 3);
			txn(rows[i][0], rows[i][1], rows[i][2], rows[i][3], rows[i][4],
				rows[i][5], 1'h1);
		end
		for (int i = 0; i < 4; i++)
			push(32'h0000_00A0 + i, 1'h1);
		push(ZERO_WORD, 1'h0);
		for (int i = 0; i < 4; i++)
			txn(32'h0000_00A0 + i, i, i, i, i, i, 1'h0);
		// Mid-run reset: flags return to their reset values
		@(negedge core_clk_i);
		rst_b_i = 1'h0;
		@(negedge core_clk_i);
		chk("quiescent_flag_o", quiescent_flag_o, 1);
		chk("sum_out_valid_o", sum_out_valid_o, 0);
		chk("finish_pulse_o", finish_pulse_o, 0);
		rst_b_i = 1'h1;
		txn(32'h0000_0011, 1, 2, 3, 4, 5, 1'h1);
		results;
	end
endmodule
`default_nettype wire
